// ==== hdl/buf_counter.sv ====
// saturating packet buffer counter
`timescale 1ns/1ps
`include "eth_status_map.svh"
module buf_counter import eth_status_pkg::*; #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // count events
    input wire logic inc,
    input wire logic [WIDTH-1:0] inc_amount,
    input wire logic dec,
    input wire logic clear,
    // value
    output logic [WIDTH-1:0] count
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    cnt_state_t state_ff;
    cnt_state_t nxt_state;

    function automatic logic [WIDTH-1:0] sat_add(input logic [WIDTH-1:0] a, input logic [WIDTH-1:0] b);
        logic [WIDTH:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[WIDTH] ? {WIDTH{1'b1}} : s[WIDTH-1:0];
    endfunction

    always_comb begin
        nxt_state = state_ff;
        if (clear) begin
            nxt_state.count = '0; // R14
        end else if (inc && dec) begin
            nxt_state.count = state_ff.count; // R10
        end else if (inc) begin
            nxt_state.count = sat_add(state_ff.count, inc_amount); // R6 R8
        end else if (dec && state_ff.count != '0) begin
            nxt_state.count = state_ff.count - 1'b1; // R9 R21
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign count = state_ff.count;

    property p_no_wrap_up;
        @(posedge clk) disable iff (!rstn) (&state_ff.count && inc && !dec && !clear) |=> &state_ff.count;
    endproperty
    a_no_wrap_up: assert property (p_no_wrap_up) else $error("count wrapped above max"); // R8

    property p_no_wrap_down;
        @(posedge clk) disable iff (!rstn) (state_ff.count == '0 && dec && !inc && !clear) |=> state_ff.count == '0;
    endproperty
    a_no_wrap_down: assert property (p_no_wrap_down) else $error("count wrapped below zero"); // R9

    property p_tie;
        @(posedge clk) disable iff (!rstn) (inc && dec && !clear) |=> $stable(state_ff.count);
    endproperty
    a_tie: assert property (p_tie) else $error("count moved on tie"); // R10

    property p_dec_one;
        @(posedge clk) disable iff (!rstn)
            (dec && !inc && !clear && state_ff.count != '0) |=> state_ff.count == $past(state_ff.count) - 1'b1;
    endproperty
    a_dec_one: assert property (p_dec_one) else $error("decrement not by one"); // R21
endmodule

// ==== hdl/eth_status.sv ====
// ethernet status flags, buffer count and busy indicators with apb registers
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "eth_status_map.svh"
module eth_status import eth_status_pkg::*; #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit path events
    input wire logic tx_active,
    input wire logic tx_abort_event,
    // receive path events
    input wire logic rx_active,
    input wire logic rx_packet_done,
    input wire logic [CNT_W-1:0] rx_desc_used,
    input wire logic rx_desc_overrun,
    input wire logic rx_fifo_overflow,
    // module transaction in flight
    input wire logic bus_txn_active,
    // outputs to system
    output logic rx_halt,
    output logic packet_pending_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] flags;
        logic pend;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic on;
        logic flow_en;
        logic pend_ie;
        logic dec_pulse;
        logic clr_cnt;
        pwr_state_t pwr;
        logic tx_busy;
        logic rx_busy;
        logic halt;
        logic irq;
    } st_t;

    st_t s_ff;
    st_t nxt_s;
    logic [CNT_W-1:0] cnt;
    logic cnt_inc;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
        is_addr = (a == ofs);
    endfunction

    // the four flag aliases all read back the flag word
    function automatic logic is_flag_alias(input logic [11:0] a);
        is_flag_alias = is_addr(a, `OFS_IRQ_FLAGS) || is_addr(a, `OFS_IRQ_SET) ||
            is_addr(a, `OFS_IRQ_CLR) || is_addr(a, `OFS_IRQ_INV);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_flag_alias(a) || is_addr(a, `OFS_STATUS) || is_addr(a, `OFS_CONTROL) ||
            is_addr(a, `OFS_IRQ_ENABLE) || is_addr(a, `OFS_RX_START);
    endfunction

    // ----------------------------------------
    // buffer counter
    // ----------------------------------------
    // not gated by halt: a halted receiver completes no packets, and saturation covers the rest
    assign cnt_inc = rx_packet_done;

    buf_counter #(
        .WIDTH(CNT_W)
    ) u_cnt (
        .clk(clk),
        .rstn(rstn),
        .inc(cnt_inc),
        .inc_amount(rx_desc_used),
        .dec(s_ff.dec_pulse),
        .clear(s_ff.clr_cnt),
        .count(cnt)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic acc;
        logic wr;
        logic [2:0] wflags;
        logic [2:0] sets;
        acc = psel && penable && !s_ff.ready;
        wr = acc && pwrite;
        wflags = pwdata[2:0];
        sets = '0;
        nxt_s = s_ff;
        nxt_s.ready = acc;
        nxt_s.err = 1'b0;
        nxt_s.dec_pulse = 1'b0;
        nxt_s.clr_cnt = 1'b0;
        // software side of the three event flags
        if (wr && is_addr(paddr, `OFS_IRQ_FLAGS)) begin
            nxt_s.flags = wflags;
        end else if (wr && is_addr(paddr, `OFS_IRQ_SET)) begin
            nxt_s.flags = s_ff.flags | wflags;
        end else if (wr && is_addr(paddr, `OFS_IRQ_CLR)) begin
            nxt_s.flags = s_ff.flags & ~wflags; // R2 R3 R4
        end else if (wr && is_addr(paddr, `OFS_IRQ_INV)) begin
            nxt_s.flags = s_ff.flags ^ wflags;
        end
        // hardware set wins over a clear in the same cycle
        sets[`BIT_TX_ABORT] = tx_abort_event; // R1
        sets[`BIT_RX_DESC_NA] = rx_desc_overrun; // R3
        sets[`BIT_RX_OVFL] = rx_fifo_overflow; // R4
        nxt_s.flags = nxt_s.flags | sets;
        if (wr && is_addr(paddr, `OFS_CONTROL)) begin
            nxt_s.on = pwdata[`BIT_CTRL_ON];
            nxt_s.flow_en = pwdata[`BIT_CTRL_FLOW];
            nxt_s.dec_pulse = pwdata[`BIT_CTRL_DEC]; // R7 R21
        end
        if (wr && is_addr(paddr, `OFS_IRQ_ENABLE)) begin
            nxt_s.pend_ie = pwdata[`BIT_PKT_PEND];
        end
        if (wr && is_addr(paddr, `OFS_RX_START)) begin
            nxt_s.clr_cnt = 1'b1; // R14
        end
        // pending follows the count; direct flag writes never touch it
        nxt_s.pend = (cnt != '0); // R13 R20
        nxt_s.irq = nxt_s.pend && s_ff.pend_ie; // R13
        // halt only under flow control; count survives switch-off
        nxt_s.halt = s_ff.flow_en && (cnt == `CNT_MAX); // R11 R12 R15
        nxt_s.tx_busy = s_ff.on && tx_active; // R17
        nxt_s.rx_busy = s_ff.on && rx_active; // R18
        case (s_ff.pwr)
            PWR_OFF: if (s_ff.on) nxt_s.pwr = PWR_ON;
            PWR_ON: if (!s_ff.on) nxt_s.pwr = bus_txn_active ? PWR_DRAIN : PWR_OFF; // R16
            PWR_DRAIN: begin
                if (s_ff.on) begin
                    nxt_s.pwr = PWR_ON;
                end else if (!bus_txn_active) begin
                    nxt_s.pwr = PWR_OFF; // R16
                end
            end
            default: nxt_s.pwr = PWR_OFF;
        endcase
        // read data
        nxt_s.rdata = '0;
        if (acc && !pwrite) begin
            if (is_flag_alias(paddr)) begin
                nxt_s.rdata[2:0] = s_ff.flags;
                nxt_s.rdata[`BIT_PKT_PEND] = s_ff.pend;
            end else if (is_addr(paddr, `OFS_STATUS)) begin
                // unlisted bits stay zero
                nxt_s.rdata[`CNT_LSB +: CNT_W] = cnt; // R19
                nxt_s.rdata[`BIT_MOD_BUSY] = (s_ff.pwr != PWR_OFF); // R16
                nxt_s.rdata[`BIT_TX_BUSY] = s_ff.tx_busy; // R17
                nxt_s.rdata[`BIT_RX_BUSY] = s_ff.rx_busy; // R18
            end else if (is_addr(paddr, `OFS_CONTROL)) begin
                nxt_s.rdata[`BIT_CTRL_ON] = s_ff.on;
                nxt_s.rdata[`BIT_CTRL_FLOW] = s_ff.flow_en;
            end else if (is_addr(paddr, `OFS_IRQ_ENABLE)) begin
                nxt_s.rdata[`BIT_PKT_PEND] = s_ff.pend_ie;
            end else if (!is_addr(paddr, `OFS_RX_START)) begin
                nxt_s.err = 1'b1;
            end
        end else if (wr) begin
            nxt_s.err = !is_mapped(paddr);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '{flags: `FLAGS_RST, pwr: PWR_OFF, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = s_ff.rdata;
    assign pready = s_ff.ready;
    assign pslverr = s_ff.err;
    assign rx_halt = s_ff.halt;
    assign packet_pending_irq = s_ff.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_abort_set;
        @(posedge clk) disable iff (!rstn) tx_abort_event |=> s_ff.flags[`BIT_TX_ABORT];
    endproperty
    a_abort_set: assert property (p_abort_set) else $error("abort flag not set"); // R1

    property p_abort_hold;
        @(posedge clk) disable iff (!rstn)
            (s_ff.flags[`BIT_TX_ABORT] && !(psel && penable && pwrite)) |=> s_ff.flags[`BIT_TX_ABORT];
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort flag dropped"); // R2

    property p_desc_set;
        @(posedge clk) disable iff (!rstn) rx_desc_overrun |=> s_ff.flags[`BIT_RX_DESC_NA];
    endproperty
    a_desc_set: assert property (p_desc_set) else $error("descriptor flag not set"); // R3

    property p_ovfl_set;
        @(posedge clk) disable iff (!rstn) rx_fifo_overflow |=> s_ff.flags[`BIT_RX_OVFL];
    endproperty
    a_ovfl_set: assert property (p_ovfl_set) else $error("overflow flag not set"); // R4

    property p_inc;
        @(posedge clk) disable iff (!rstn)
            (cnt_inc && !s_ff.dec_pulse && !s_ff.clr_cnt && cnt == '0) |=> cnt == $past(rx_desc_used);
    endproperty
    a_inc: assert property (p_inc) else $error("count not incremented"); // R6

    property p_halt;
        @(posedge clk) disable iff (!rstn) (s_ff.flow_en && cnt == `CNT_MAX) |=> rx_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt at max"); // R11

    property p_no_halt;
        @(posedge clk) disable iff (!rstn) !s_ff.flow_en |=> !rx_halt;
    endproperty
    a_no_halt: assert property (p_no_halt) else $error("halt without flow control"); // R12

    property p_pend;
        @(posedge clk) disable iff (!rstn) (cnt != '0) |=> s_ff.pend;
    endproperty
    a_pend: assert property (p_pend) else $error("pending not set"); // R13 R20

    property p_rxst_clr;
        @(posedge clk) disable iff (!rstn)
            (psel && penable && pwrite && !pready && paddr == `OFS_RX_START) |=> ##1 cnt == '0;
    endproperty
    a_rxst_clr: assert property (p_rxst_clr) else $error("start write did not clear count"); // R14

    property p_keep_off;
        @(posedge clk) disable iff (!rstn)
            ($fell(s_ff.on) && !cnt_inc && !s_ff.dec_pulse && !s_ff.clr_cnt) |=> $stable(cnt);
    endproperty
    a_keep_off: assert property (p_keep_off) else $error("count changed on switch-off"); // R15

    property p_busy_on;
        @(posedge clk) disable iff (!rstn) s_ff.on |-> ##2 s_ff.pwr != PWR_OFF || !s_ff.on;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("module busy low while on"); // R16

    property p_txrx_off;
        @(posedge clk) disable iff (!rstn) !s_ff.on |=> !s_ff.tx_busy && !s_ff.rx_busy;
    endproperty
    a_txrx_off: assert property (p_txrx_off) else $error("busy while off"); // R17 R18

    property p_ready_one;
        @(posedge clk) disable iff (!rstn) pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready held over one cycle");

    property p_ready_ack;
        @(posedge clk) disable iff (!rstn) (psel && penable && !pready) |=> pready;
    endproperty
    a_ready_ack: assert property (p_ready_ack) else $error("no answer after one wait state");

    property p_rdata_idle;
        @(posedge clk) disable iff (!rstn) !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

    property p_err_ready;
        @(posedge clk) disable iff (!rstn) pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_desc_hold;
        @(posedge clk) disable iff (!rstn)
            (s_ff.flags[`BIT_RX_DESC_NA] && !(psel && penable && pwrite)) |=> s_ff.flags[`BIT_RX_DESC_NA];
    endproperty
    a_desc_hold: assert property (p_desc_hold) else $error("descriptor flag dropped"); // R3

    property p_ovfl_hold;
        @(posedge clk) disable iff (!rstn)
            (s_ff.flags[`BIT_RX_OVFL] && !(psel && penable && pwrite)) |=> s_ff.flags[`BIT_RX_OVFL];
    endproperty
    a_ovfl_hold: assert property (p_ovfl_hold) else $error("overflow flag dropped"); // R4

    property p_clr_cnt;
        @(posedge clk) disable iff (!rstn) s_ff.clr_cnt |=> cnt == '0;
    endproperty
    a_clr_cnt: assert property (p_clr_cnt) else $error("clear pulse left count"); // R14

    property p_pend_clr;
        @(posedge clk) disable iff (!rstn) (cnt == '0) |=> !s_ff.pend;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending kept at zero count"); // R20

    property p_irq_mask;
        @(posedge clk) disable iff (!rstn) !s_ff.pend_ie |=> !packet_pending_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled"); // R13

    property p_status_zero;
        @(posedge clk) disable iff (!rstn) (pready && psel && !pwrite && paddr == `OFS_STATUS) |->
            (prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00 && prdata[4:0] == 5'h00);
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("reserved status bits set"); // R19

    property p_on_busy;
        @(posedge clk) disable iff (!rstn) $rose(s_ff.on) |=> s_ff.pwr == PWR_ON;
    endproperty
    a_on_busy: assert property (p_on_busy) else $error("module busy not raised"); // R16

    property p_drain;
        @(posedge clk) disable iff (!rstn) (s_ff.pwr == PWR_ON && !s_ff.on && bus_txn_active) |=> s_ff.pwr == PWR_DRAIN;
    endproperty
    a_drain: assert property (p_drain) else $error("no drain on switch-off"); // R16

    property p_drain_end;
        @(posedge clk) disable iff (!rstn)
            (s_ff.pwr == PWR_DRAIN && !s_ff.on && !bus_txn_active) |=> s_ff.pwr == PWR_OFF;
    endproperty
    a_drain_end: assert property (p_drain_end) else $error("busy after transaction end"); // R16

    property p_tx_follow;
        @(posedge clk) disable iff (!rstn) (s_ff.on && tx_active) |=> s_ff.tx_busy;
    endproperty
    a_tx_follow: assert property (p_tx_follow) else $error("transmit busy missing"); // R17

    property p_rx_follow;
        @(posedge clk) disable iff (!rstn) (s_ff.on && rx_active) |=> s_ff.rx_busy;
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("receive busy missing"); // R18

    c_abort: cover property (@(posedge clk) disable iff (!rstn) tx_abort_event ##1 s_ff.flags[`BIT_TX_ABORT]);
    c_sat: cover property (@(posedge clk) disable iff (!rstn) cnt == `CNT_MAX && cnt_inc);
    c_halt: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_halt));
    c_drain: cover property (@(posedge clk) disable iff (!rstn) s_ff.pwr == PWR_DRAIN);
    c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(packet_pending_irq));
endmodule

// ==== shared/eth_status_map.svh ====
// offsets, field positions, reset values and limits for the status block
// ----------------------------------------
// Operation
// R1: raise transmit-abort flag on any mac abort cause
// R2: transmit-abort flag holds until reset or a one written via clear alias; code also clears it on a direct flag write or an invert-alias one
// R3: descriptor overrun sets descriptor-unavailable flag bit 1; clear alias or reset clears
// R4: rx fifo overflow sets overflow flag bit 0; clear alias or reset clears
// R5: software should touch flags only via set, clear, invert aliases
// R6: good packet adds its descriptor count to buffer count bits 23-16
// R7: software pulses decrement bit once per descriptor after reading packet
// R8: hardware increment at 0xff leaves count at 0xff
// R9: software decrement at 0x00 leaves count at zero
// R10: simultaneous increment and decrement leave count unchanged
// R11: with flow control on, receive halts at 0xff until decremented below
// R12: with flow control off, receive dma keeps going while count saturated
// R13: packet-pending flag set while count nonzero; irq only when enabled
// R14: any write to rx start address register clears count to 0x00
// R15: switching module off does not clear the count
// R16: module busy bit 7 is on while enabled, then until transaction ends
// R17: transmit busy bit 6 follows transmission, forced zero when off
// R18: receive busy bit 5 follows reception, forced zero when off
// R19: status bits 31-24, 15-8 and 4-0 read zero
// R20: packet-pending clears only by reset or decrement to zero; writes ignored; code also clears it when an rx start write clears the count
// R21: each decrement pulse lowers count by one in the following cycle
// ----------------------------------------
`ifndef ETH_STATUS_MAP_SVH
`define ETH_STATUS_MAP_SVH

// register byte addresses
`define OFS_IRQ_FLAGS 12'h000
`define OFS_IRQ_SET 12'h004
`define OFS_IRQ_CLR 12'h008
`define OFS_IRQ_INV 12'h00c
`define OFS_STATUS 12'h010
`define OFS_CONTROL 12'h014
`define OFS_IRQ_ENABLE 12'h018
`define OFS_RX_START 12'h01c

// field positions
`define BIT_RX_OVFL 0
`define BIT_RX_DESC_NA 1
`define BIT_TX_ABORT 2
`define BIT_PKT_PEND 6
`define BIT_RX_BUSY 5
`define BIT_TX_BUSY 6
`define BIT_MOD_BUSY 7
`define CNT_LSB 16
`define BIT_CTRL_DEC 0
`define BIT_CTRL_FLOW 1
`define BIT_CTRL_ON 15

// reset values and limits
`define CNT_MAX 8'hff
`define CNT_ZERO 8'h00
`define FLAGS_RST 3'h0

`endif

// ==== shared/eth_status_pkg.sv ====
// types for the status block
package eth_status_pkg;
    typedef enum logic [2:0] {
        PWR_OFF = 3'b001,
        PWR_ON = 3'b010,
        PWR_DRAIN = 3'b100
    } pwr_state_t;
endpackage

// ==== tb/eth_mac_model.sv ====
// behavioural model of the mac and receive dma event side
`timescale 1ns/1ps
module eth_mac_model (
    // clock
    input wire logic clk,
    // events and levels toward the status block
    output logic tx_active,
    output logic tx_abort_event,
    output logic rx_active,
    output logic rx_packet_done,
    output logic [7:0] rx_desc_used,
    output logic rx_desc_overrun,
    output logic rx_fifo_overflow,
    output logic bus_txn_active
);
    initial begin
        {tx_active, tx_abort_event, rx_active, rx_packet_done} = 4'h0;
        {rx_desc_overrun, rx_fifo_overflow, bus_txn_active} = 3'h0;
        rx_desc_used = 8'h5a;
    end
    // ----------------------------------------
    // one-cycle fault pulses, mask in flag order: 0 overflow, 1 descriptor overrun, 2 abort
    // ----------------------------------------
    task automatic fault(input logic [2:0] m);
        @(posedge clk);
        {tx_abort_event, rx_desc_overrun, rx_fifo_overflow} <= m;
        @(posedge clk);
        {tx_abort_event, rx_desc_overrun, rx_fifo_overflow} <= 3'h0;
    endtask
    // descriptor count is only valid with the done pulse; garbage otherwise
    task automatic packet(input logic [7:0] n);
        @(posedge clk);
        rx_active <= 1'h1;
        @(posedge clk);
        rx_packet_done <= 1'h1;
        rx_desc_used <= n;
        @(posedge clk);
        rx_packet_done <= 1'h0;
        rx_active <= 1'h0;
        rx_desc_used <= ~n;
    endtask
    task automatic levels(input logic tx, input logic rx, input logic txn);
        @(posedge clk);
        tx_active <= tx;
        rx_active <= rx;
        bus_txn_active <= txn;
    endtask
endmodule

// ==== tb/eth_status_tb.sv ====
// self-checking bench for the ethernet status block
`timescale 1ns/1ps
`include "eth_status_map.svh"
module eth_status_tb;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tx_active, tx_abort_event, rx_active, rx_packet_done, rx_desc_overrun;
    logic rx_fifo_overflow, bus_txn_active, rx_halt, packet_pending_irq;
    logic [7:0] rx_desc_used;
    int num_errors = 0;
    int cmp_count = 0;

    eth_status u_eth_status (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_active(tx_active), .tx_abort_event(tx_abort_event), .rx_active(rx_active),
        .rx_packet_done(rx_packet_done), .rx_desc_used(rx_desc_used), .rx_desc_overrun(rx_desc_overrun),
        .rx_fifo_overflow(rx_fifo_overflow), .bus_txn_active(bus_txn_active), .rx_halt(rx_halt),
        .packet_pending_irq(packet_pending_irq));
    eth_mac_model u_eth_mac_model (.clk(clk), .tx_active(tx_active), .tx_abort_event(tx_abort_event),
        .rx_active(rx_active), .rx_packet_done(rx_packet_done), .rx_desc_used(rx_desc_used),
        .rx_desc_overrun(rx_desc_overrun), .rx_fifo_overflow(rx_fifo_overflow),
        .bus_txn_active(bus_txn_active));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // apb master and compare helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until pready is seen at a rising edge; no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rstn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rdchk("status reset", `OFS_STATUS, 32'h0);
        for (int k = 0; k < 3; k++) begin
            u_eth_mac_model.fault(3'h1 << k);
            rdchk("flag set", `OFS_IRQ_FLAGS, 32'h1 << k);
            wr(`OFS_IRQ_CLR, ~(32'h1 << k) & 32'h7);
            rdchk("flag held", `OFS_IRQ_FLAGS, 32'h1 << k);
            wr(`OFS_IRQ_CLR, 32'h1 << k);
            rdchk("flag cleared", `OFS_IRQ_FLAGS, 32'h0);
        end
        u_eth_mac_model.fault(3'h4);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rdchk("reset clears", `OFS_IRQ_FLAGS, 32'h0);
        // clear write and abort pulse meet at one edge: the set must win
        fork
            wr(`OFS_IRQ_CLR, 32'h4);
            begin
                @(posedge clk);
                u_eth_mac_model.fault(3'h4);
            end
        join
        rdchk("set beats clear", `OFS_IRQ_FLAGS, 32'h4);
        wr(`OFS_IRQ_SET, 32'h5);
        rdchk("alias set", `OFS_IRQ_FLAGS, 32'h5);
        wr(`OFS_IRQ_INV, 32'h5);
        rdchk("alias invert", `OFS_IRQ_FLAGS, 32'h0);
        u_eth_mac_model.packet(8'h03);
        rdchk("count add", `OFS_STATUS, 32'h0003_0000);
        rdchk("pending", `OFS_IRQ_FLAGS, 32'h40);
        chk("irq masked", 32'h0, {31'h0, packet_pending_irq});
        wr(`OFS_IRQ_ENABLE, 32'h40);
        settle(3);
        chk("irq on", 32'h1, {31'h0, packet_pending_irq});
        wr(`OFS_IRQ_CLR, 32'h40);
        wr(`OFS_IRQ_FLAGS, 32'h0);
        rdchk("pending kept", `OFS_IRQ_FLAGS, 32'h40);
        wr(`OFS_CONTROL, 32'h1);
        rdchk("dec one", `OFS_STATUS, 32'h0002_0000);
        wr(`OFS_CONTROL, 32'h1);
        wr(`OFS_CONTROL, 32'h1);
        rdchk("pending off", `OFS_IRQ_FLAGS, 32'h0);
        settle(3);
        chk("irq off", 32'h0, {31'h0, packet_pending_irq});
        wr(`OFS_CONTROL, 32'h1);
        rdchk("no underflow", `OFS_STATUS, 32'h0);
        u_eth_mac_model.packet(8'hfe);
        u_eth_mac_model.packet(8'h05);
        rdchk("saturate", `OFS_STATUS, 32'h00ff_0000);
        wr(`OFS_CONTROL, 32'h2);
        settle(2);
        chk("halt", 32'h1, {31'h0, rx_halt});
        wr(`OFS_CONTROL, 32'h3);
        rdchk("below max", `OFS_STATUS, 32'h00fe_0000);
        chk("resume", 32'h0, {31'h0, rx_halt});
        u_eth_mac_model.packet(8'h01);
        wr(`OFS_CONTROL, 32'h0);
        u_eth_mac_model.packet(8'h01);
        rdchk("still max", `OFS_STATUS, 32'h00ff_0000);
        chk("no halt", 32'h0, {31'h0, rx_halt});
        wr(`OFS_RX_START, 32'h0000_1000);
        rdchk("start clears", `OFS_STATUS, 32'h0);
        u_eth_mac_model.packet(8'h02);
        wr(`OFS_CONTROL, 32'h8000);
        u_eth_mac_model.levels(1'h1, 1'h1, 1'h0);
        rdchk("busy on", `OFS_STATUS, 32'h0002_00e0);
        u_eth_mac_model.levels(1'h1, 1'h1, 1'h1);
        wr(`OFS_CONTROL, 32'h0);
        rdchk("off draining", `OFS_STATUS, 32'h0002_0080);
        u_eth_mac_model.levels(1'h0, 1'h0, 1'h0);
        rdchk("off idle", `OFS_STATUS, 32'h0002_0000);
        apb(1'h0, 12'h020, 32'h0);
        chk("unmapped read", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'h1, 12'h020, 32'h7);
        chk("unmapped write", 32'h1, {31'h0, err});
        finish_test;
    end
    // bound well above the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test;
    end
endmodule
